/* File: inc/sepi_pkg.sv */
package sepi_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS   = 8;
  localparam int TWR_NS   = 5000000;
  localparam int TWR_CYC  = TWR_NS / CLK_NS;
  localparam int TPUP_NS  = 100000;
  localparam int TPUP_CYC = (TPUP_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 8;
  localparam int PAGE_W  = 7;
  localparam int STRAP_W = 3;

  // ---------------------------------------------------------------
  // Device-select byte layout
  // ---------------------------------------------------------------
  localparam int         PREFIX_W       = 4;
  localparam int         SEL_RW_BIT     = 0;
  localparam int         SEL_STRAP_LSB  = 1;
  localparam int         SEL_PREFIX_LSB = 4;
  localparam logic [3:0] DEV_PREFIX     = 4'ha;

  // ---------------------------------------------------------------
  // Bit slot counter
  // ---------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEV,
    S_AHI,
    S_ALO,
    S_WR,
    S_RD
  } sepi_state_e;

endpackage : sepi_pkg

/* File: rtl/sepi_link_cap.sv */
`timescale 1ns/1ps
`default_nettype none

module sepi_link_cap (
  input  wire logic scl_clk,
  input  wire logic link_clr,
  input  wire logic sda_in,
  output logic      bit_q,
  output logic      tgl_q
);

  logic bit_d;
  logic tgl_d;

  always_comb begin
    bit_d = sda_in;
    tgl_d = ~tgl_q;
  end

  // Clear comes from the system side; SCL may stand still under reset
  always_ff @(posedge scl_clk or posedge link_clr) begin
    if (link_clr) begin
      bit_q <= 1'h0;
      tgl_q <= 1'h0;
    end else begin
      bit_q <= bit_d;
      tgl_q <= tgl_d;
    end
  end

endmodule : sepi_link_cap

`default_nettype wire

/* File: rtl/sepi_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module sepi_mem #(
  parameter int ADDR_W = sepi_pkg::ADDR_W,
  parameter int DATA_W = sepi_pkg::DATA_W
) (
  input  wire logic              clk,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [DATA_W-1:0] rdata_q
);

  logic [DATA_W-1:0] mem_q [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata_q <= mem_q[raddr];
  end

endmodule : sepi_mem

`default_nettype wire

/* File: rtl/sepi_eeprom.sv */
// Functional notes
// - Answer only when received strap bits equal the three strap inputs; eight share a bus.
// - Undriven strap or write-protect inputs count as low.
// - Command and data bits are captured on rising serial clock.
// - Read data on the data line changes only after a falling serial clock.
// - Data line is only pulled low or released, never driven high.
// - Write-protect high blocks every write to the whole array.
// - Write-protect low lets write commands proceed normally.
// - Array holds 65,536 bytes selected by a 16-bit address.
// - All bus commands are ignored until power-on reset releases the device.
`timescale 1ns/1ps
`default_nettype none

module sepi_eeprom #(
  parameter int WRITE_CYC = sepi_pkg::TWR_CYC,
  parameter int PUP_CYC   = sepi_pkg::TPUP_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic scl_clk,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic address_strap_0,
  input  wire logic address_strap_1,
  input  wire logic address_strap_2,
  input  wire logic write_protect
);

  localparam int BUSY_W = $clog2(WRITE_CYC + 1);
  localparam int PUP_W  = $clog2(PUP_CYC + 1);
  localparam int AW     = sepi_pkg::ADDR_W;
  localparam int DW     = sepi_pkg::DATA_W;
  localparam int PW     = sepi_pkg::PAGE_W;
  localparam int SW     = sepi_pkg::STRAP_W;

  // Positions in the synchroniser vector
  localparam int IX_SCL   = 0;
  localparam int IX_SDA   = 1;
  localparam int IX_BIT   = 2;
  localparam int IX_TGL   = 3;
  localparam int IX_STRAP = 4;
  localparam int IX_WP    = IX_STRAP + SW;
  localparam int NSYNC    = IX_WP + 1;

  // ---------------------------------------------------------------
  // Link side capture
  // ---------------------------------------------------------------
  logic link_clr_q;
  logic link_clr_d;
  logic cap_bit;
  logic cap_tgl;

  sepi_link_cap u_cap (
    .scl_clk  (scl_clk),
    .link_clr (link_clr_q),
    .sda_in   (sda_in),
    .bit_q    (cap_bit),
    .tgl_q    (cap_tgl)
  );

  always_comb begin
    link_clr_d = 1'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      link_clr_q <= 1'h1;
    end else begin
      link_clr_q <= link_clr_d;
    end
  end

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [NSYNC-1:0] sync_raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] s1_d;
  logic [NSYNC-1:0] s2_d;
  logic [NSYNC-1:0] s3_d;
  logic             tgl_s4_q;
  logic             tgl_s4_d;

  always_comb begin
    sync_raw                     = '0;
    sync_raw[IX_SCL]             = scl_clk;
    sync_raw[IX_SDA]             = sda_in;
    sync_raw[IX_BIT]             = cap_bit;
    sync_raw[IX_TGL]             = cap_tgl;
    // Floating pins read as low
    sync_raw[IX_STRAP]           = (address_strap_0 === 1'h1);
    sync_raw[IX_STRAP+1]         = (address_strap_1 === 1'h1);
    sync_raw[IX_STRAP+2]         = (address_strap_2 === 1'h1);
    sync_raw[IX_WP]              = (write_protect === 1'h1);
    s1_d                         = sync_raw;
    s2_d                         = s1_q;
    s3_d                         = s2_q;
    tgl_s4_d                     = s3_q[IX_TGL];
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      tgl_s4_q <= 1'h0;
    end else begin
      s1_q     <= s1_d;
      s2_q     <= s2_d;
      s3_q     <= s3_d;
      tgl_s4_q <= tgl_s4_d;
    end
  end

  logic          rise_ev;
  logic          fall_ev;
  logic          start_ev;
  logic          stop_ev;
  logic          bit_s;
  logic          wp_s;
  logic [SW-1:0] strap_s;

  always_comb begin
    // Edge seen one stage late so the captured bit has settled
    rise_ev  = s3_q[IX_TGL] ^ tgl_s4_q;
    bit_s    = s2_q[IX_BIT];
    fall_ev  = s3_q[IX_SCL] & ~s2_q[IX_SCL];
    start_ev = s2_q[IX_SCL] & s3_q[IX_SCL] & s3_q[IX_SDA] & ~s2_q[IX_SDA];
    stop_ev  = s2_q[IX_SCL] & s3_q[IX_SCL] & ~s3_q[IX_SDA] & s2_q[IX_SDA];
    wp_s     = s2_q[IX_WP];
    strap_s  = s2_q[IX_STRAP +: SW];
  end

  // ---------------------------------------------------------------
  // Power-on hold-off
  // ---------------------------------------------------------------
  logic [PUP_W-1:0] por_cnt_q;
  logic [PUP_W-1:0] por_cnt_d;
  logic             por_done;

  always_comb begin
    por_done  = (por_cnt_q == PUP_W'(PUP_CYC));
    por_cnt_d = por_done ? por_cnt_q : por_cnt_q + 1'h1;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      por_cnt_q <= '0;
    end else begin
      por_cnt_q <= por_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // Array
  // ---------------------------------------------------------------
  logic          mem_we;
  logic [DW-1:0] rd_data;
  logic [DW-1:0] byte_in;
  logic [AW-1:0] addr_q;

  sepi_mem #(
    .ADDR_W (AW),
    .DATA_W (DW)
  ) u_mem (
    .clk     (sys_clk),
    .we      (mem_we),
    .waddr   (addr_q),
    .wdata   (byte_in),
    .raddr   (addr_q),
    .rdata_q (rd_data)
  );

  // ---------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------
  sepi_pkg::sepi_state_e st_q;
  sepi_pkg::sepi_state_e st_d;
  logic [3:0]            cnt_q;
  logic [3:0]            cnt_d;
  logic [DW-1:0]         shf_q;
  logic [DW-1:0]         shf_d;
  logic [AW-1:0]         addr_d;
  logic                  ack_q;
  logic                  ack_d;
  logic                  wrote_q;
  logic                  wrote_d;
  logic [BUSY_W-1:0]     busy_q;
  logic [BUSY_W-1:0]     busy_d;
  logic                  oe_q;
  logic                  oe_d;
  logic                  dev_match;
  logic [2:0]            rd_idx;

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    shf_d     = shf_q;
    addr_d    = addr_q;
    ack_d     = ack_q;
    wrote_d   = wrote_q;
    busy_d    = busy_q;
    oe_d      = oe_q;
    mem_we    = 1'h0;
    byte_in   = {shf_q[DW-2:0], bit_s};
    rd_idx    = 3'(sepi_pkg::BIT_LAST - cnt_q);
    dev_match = (byte_in[sepi_pkg::SEL_PREFIX_LSB +: sepi_pkg::PREFIX_W]
                 == sepi_pkg::DEV_PREFIX)
              && (byte_in[sepi_pkg::SEL_STRAP_LSB +: SW] == strap_s)
              && (busy_q == '0);
    if (busy_q != '0) begin
      busy_d = busy_q - 1'h1;
    end
    if (!por_done) begin
      st_d = sepi_pkg::S_IDLE;
      oe_d = 1'h0;
    end else if (start_ev) begin
      st_d  = sepi_pkg::S_DEV;
      cnt_d = sepi_pkg::BIT_FIRST;
      ack_d = 1'h0;
      oe_d  = 1'h0;
    end else if (stop_ev) begin
      st_d = sepi_pkg::S_IDLE;
      oe_d = 1'h0;
      // Internal write cycle keeps the device deaf to its select byte
      if (wrote_q) begin
        busy_d  = BUSY_W'(WRITE_CYC);
        wrote_d = 1'h0;
      end
    end else begin
      if (rise_ev && st_q != sepi_pkg::S_IDLE) begin
        if (cnt_q != sepi_pkg::BIT_ACK) begin
          shf_d = byte_in;
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == sepi_pkg::BIT_LAST) begin
            unique case (st_q)
              sepi_pkg::S_DEV: ack_d = dev_match;
              sepi_pkg::S_AHI: ack_d = 1'h1;
              sepi_pkg::S_ALO: ack_d = 1'h1;
              sepi_pkg::S_WR: begin
                ack_d   = !wp_s;
                mem_we  = !wp_s;
                wrote_d = wrote_q | !wp_s;
              end
              sepi_pkg::S_RD:   ack_d = 1'h0;
              sepi_pkg::S_IDLE: ack_d = 1'h0;
            endcase
          end
        end else begin
          cnt_d = sepi_pkg::BIT_FIRST;
          unique case (st_q)
            sepi_pkg::S_DEV: begin
              if (!ack_q) begin
                st_d = sepi_pkg::S_IDLE;
              end else if (shf_q[sepi_pkg::SEL_RW_BIT]) begin
                st_d = sepi_pkg::S_RD;
              end else begin
                st_d = sepi_pkg::S_AHI;
              end
            end
            sepi_pkg::S_AHI: begin
              addr_d[AW-1:DW] = shf_q;
              st_d            = sepi_pkg::S_ALO;
            end
            sepi_pkg::S_ALO: begin
              addr_d[DW-1:0] = shf_q;
              st_d           = sepi_pkg::S_WR;
            end
            sepi_pkg::S_WR: begin
              if (ack_q) begin
                // Rolls over inside the page
                addr_d[PW-1:0] = addr_q[PW-1:0] + PW'(1);
              end else begin
                st_d = sepi_pkg::S_IDLE;
              end
            end
            sepi_pkg::S_RD: begin
              if (bit_s) begin
                st_d = sepi_pkg::S_IDLE;
              end else begin
                addr_d = addr_q + AW'(1);
              end
            end
            sepi_pkg::S_IDLE: st_d = sepi_pkg::S_IDLE;
          endcase
        end
      end
      if (fall_ev) begin
        if (st_q == sepi_pkg::S_RD) begin
          oe_d = (cnt_q != sepi_pkg::BIT_ACK) && !rd_data[rd_idx];
        end else begin
          oe_d = (cnt_q == sepi_pkg::BIT_ACK) && ack_q;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q    <= sepi_pkg::S_IDLE;
      cnt_q   <= sepi_pkg::BIT_FIRST;
      shf_q   <= '0;
      addr_q  <= '0;
      ack_q   <= 1'h0;
      wrote_q <= 1'h0;
      busy_q  <= '0;
      oe_q    <= 1'h0;
      sda_out <= 1'h0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      shf_q   <= shf_d;
      addr_q  <= addr_d;
      ack_q   <= ack_d;
      wrote_q <= wrote_d;
      busy_q  <= busy_d;
      oe_q    <= oe_d;
      sda_out <= 1'h0;
    end
  end

  assign sda_oe = oe_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic quiet;
  assign quiet = por_done && !start_ev && !stop_ev;

  sequence seq_dev_end;
    rise_ev && quiet && st_q == sepi_pkg::S_DEV && cnt_q == sepi_pkg::BIT_LAST;
  endsequence

  sequence seq_wr_end(logic wp);
    rise_ev && quiet && st_q == sepi_pkg::S_WR && cnt_q == sepi_pkg::BIT_LAST && wp_s == wp;
  endsequence

  chk_sel_strap: assert property (
    seq_dev_end ##0 (byte_in[sepi_pkg::SEL_STRAP_LSB +: SW] != strap_s) |=> !ack_q)
    else $error("select acknowledged with strap mismatch");

  chk_sel_prefix: assert property (
    seq_dev_end ##0 (byte_in[sepi_pkg::SEL_PREFIX_LSB +: sepi_pkg::PREFIX_W]
                     != sepi_pkg::DEV_PREFIX) |=> !ack_q)
    else $error("select acknowledged with wrong prefix");

  chk_sel_accept: assert property (
    seq_dev_end ##0 dev_match |=> ack_q)
    else $error("matching select not acknowledged");

  // Falling clock that opens an acknowledge slot
  sequence seq_ack_fall;
    fall_ev && quiet && st_q != sepi_pkg::S_RD && cnt_q == sepi_pkg::BIT_ACK && ack_q;
  endsequence

  chk_ack_drive: assert property (
    seq_ack_fall |=> oe_q)
    else $error("acknowledge slot not driven");

  chk_bit_rise: assert property (
    (rise_ev && quiet && st_q != sepi_pkg::S_IDLE && cnt_q != sepi_pkg::BIT_ACK)
      |=> shf_q[0] == $past(bit_s))
    else $error("bit not taken on rising clock");

  chk_oe_fall: assert property (
    (!fall_ev && quiet) |=> $stable(oe_q))
    else $error("data line changed without falling clock");

  // Ack drive holds past the ninth rise until the next falling clock
  chk_drive_low: assert property (
    oe_q |-> !sda_out && (st_q == sepi_pkg::S_RD
      || (ack_q && (cnt_q == sepi_pkg::BIT_ACK || cnt_q == sepi_pkg::BIT_FIRST))))
    else $error("data line driven outside a low slot");

  chk_wp_block: assert property (
    seq_wr_end(1'h1) |-> !mem_we ##1 !ack_q)
    else $error("write accepted while protected");

  chk_wp_open: assert property (
    seq_wr_end(1'h0) |-> mem_we ##1 (ack_q && wrote_q))
    else $error("write refused while unprotected");

  chk_addr_wrap: assert property (
    (rise_ev && quiet && st_q == sepi_pkg::S_RD && cnt_q == sepi_pkg::BIT_ACK && !bit_s
      && addr_q == {AW{1'h1}}) |=> addr_q == '0)
    else $error("read address did not wrap");

  chk_por_quiet: assert property (
    !por_done |=> st_q == sepi_pkg::S_IDLE && !oe_q)
    else $error("bus answered before power-on release");

endmodule : sepi_eeprom

`default_nettype wire

/* File: sim/sepi_host.sv */
`timescale 1ns/1ps
`default_nettype none

module sepi_host (
  output logic      scl,
  output logic      sda_pull,
  output logic      in_cond,
  input  wire logic sda
);
  logic tick;

  // ---------------------------------------------------------------
  // Link clock, 64 ns, own phase
  // ---------------------------------------------------------------
  initial begin
    tick = 1'b0;
    #3.3;
    forever #32 tick = ~tick;
  end

  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
    in_cond  = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge tick);
  endtask : step

  task automatic start();
    in_cond  <= 1'b1;
    sda_pull <= 1'b0;
    step(1);
    scl      <= 1'b1;
    step(2);
    sda_pull <= 1'b1;
    step(2);
    scl      <= 1'b0;
    step(1);
    in_cond  <= 1'b0;
  endtask : start

  // Clock left high once the frame is over
  task automatic stop();
    sda_pull <= 1'b1;
    step(1);
    scl      <= 1'b1;
    in_cond  <= 1'b1;
    step(2);
    sda_pull <= 1'b0;
    step(2);
    in_cond  <= 1'b0;
    step(1);
  endtask : stop

  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    step(1);
    scl      <= 1'b1;
    step(1);
    r = sda;
    step(1);
    scl      <= 1'b0;
    step(1);
  endtask : bit_io

  task automatic put_byte(input logic [7:0] v, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, ack_n);
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask : get_byte
endmodule : sepi_host

`default_nettype wire

/* File: sim/sepi_eeprom_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module sepi_eeprom_tb;
  localparam int LIMIT = 60000;

  logic       sys_clk;
  logic       reset_n;
  logic [2:0] straps;
  logic       wp;
  logic [2:0] cur_s;
  logic       scl;
  logic       sda_pull;
  logic       in_cond;
  logic       sda_out;
  logic       sda_oe;
  wire logic  sda_w;
  int         mismatches;
  int         n_tests;
  int         cycles;

  // ---------------------------------------------------------------
  // Wired-AND data line with pull-up
  // ---------------------------------------------------------------
  assign sda_w = ~(sda_pull | sda_oe);

  sepi_eeprom #(.WRITE_CYC(40), .PUP_CYC(200)) i_dut (
    .sys_clk         (sys_clk),
    .reset_n         (reset_n),
    .scl_clk         (scl),
    .sda_in          (sda_w),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .address_strap_0 (straps[0]),
    .address_strap_1 (straps[1]),
    .address_strap_2 (straps[2]),
    .write_protect   (wp)
  );

  sepi_host i_host (
    .scl      (scl),
    .sda_pull (sda_pull),
    .in_cond  (in_cond),
    .sda      (sda_w)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Pin monitors
  // ---------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
      mismatches++;
      $display("MISMATCH t=%0t exp %h got %h", $time, 1'b0, sda_out);
    end
  end

  always @(sda_oe) begin
    if (reset_n === 1'b1 && scl === 1'b1 && in_cond === 1'b0) begin
      mismatches++;
      $display("MISMATCH t=%0t exp %h got %h", $time, ~sda_oe, sda_oe);
    end
  end

  task automatic check_bit(input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask : check_byte

  // ---------------------------------------------------------------
  // Shared transfers
  // ---------------------------------------------------------------
  task automatic sel(input logic [2:0] s, input logic rw, output logic ack_n);
    i_host.start();
    i_host.put_byte({sepi_pkg::DEV_PREFIX, s, rw}, ack_n);
  endtask : sel

  task automatic wr_one(input logic [15:0] a, input logic [7:0] d, input logic exp_n);
    logic k;
    sel(cur_s, 1'b0, k);
    check_bit(1'b0, k);
    i_host.put_byte(a[15:8], k);
    check_bit(1'b0, k);
    i_host.put_byte(a[7:0], k);
    check_bit(1'b0, k);
    i_host.put_byte(d, k);
    check_bit(exp_n, k);
    i_host.stop();
    i_host.step(12);
  endtask : wr_one

  task automatic rd_one(input logic [15:0] a, input logic [7:0] e);
    logic       k;
    logic [7:0] v;
    sel(cur_s, 1'b0, k);
    i_host.put_byte(a[15:8], k);
    i_host.put_byte(a[7:0], k);
    sel(cur_s, 1'b1, k);
    check_bit(1'b0, k);
    i_host.get_byte(1'b1, v);
    check_byte(e, v);
    i_host.stop();
    i_host.step(2);
  endtask : rd_one

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_hold();
    logic k;
    sel(cur_s, 1'b0, k);
    check_bit(1'b1, k);
    i_host.stop();
    i_host.step(40);
    $display("Test hold done");
  endtask : t_hold

  task automatic t_rw();
    wr_one(16'hffff, 8'h5a, 1'b0);
    wr_one(16'h7fff, 8'hc3, 1'b0);
    rd_one(16'hffff, 8'h5a);
    rd_one(16'h7fff, 8'hc3);
    $display("Test rw done");
  endtask : t_rw

  // Page write across the page end, then a read across the top address
  task automatic t_seq();
    logic       k;
    logic [7:0] v;
    sel(cur_s, 1'b0, k);
    i_host.put_byte(8'h00, k);
    i_host.put_byte(8'h7f, k);
    i_host.put_byte(8'h21, k);
    check_bit(1'b0, k);
    i_host.put_byte(8'h42, k);
    check_bit(1'b0, k);
    i_host.stop();
    i_host.step(12);
    sel(cur_s, 1'b0, k);
    i_host.put_byte(8'hff, k);
    i_host.put_byte(8'hff, k);
    sel(cur_s, 1'b1, k);
    check_bit(1'b0, k);
    i_host.get_byte(1'b0, v);
    check_byte(8'h5a, v);
    i_host.get_byte(1'b1, v);
    check_byte(8'h42, v);
    i_host.stop();
    i_host.step(2);
    $display("Test seq done");
  endtask : t_seq

  task automatic t_strap();
    logic k;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) straps <= i[2:0];
      i_host.step(2);
      sel(i[2:0], 1'b0, k);
      check_bit(1'b0, k);
      i_host.stop();
      sel(3'(i + 1), 1'b0, k);
      check_bit(1'b1, k);
      i_host.stop();
    end
    @(posedge sys_clk) straps <= cur_s;
    i_host.step(2);
    i_host.start();
    i_host.put_byte({4'hb, cur_s, 1'b0}, k);
    check_bit(1'b1, k);
    i_host.stop();
    $display("Test strap done");
  endtask : t_strap

  task automatic t_wp();
    @(posedge sys_clk) wp <= 1'b1;
    i_host.step(2);
    wr_one(16'h7fff, 8'h11, 1'b1);
    @(posedge sys_clk) wp <= 1'b0;
    i_host.step(2);
    rd_one(16'h7fff, 8'hc3);
    $display("Test wp done");
  endtask : t_wp

  task automatic t_float();
    @(posedge sys_clk) begin
      straps <= 3'bzzz;
      wp     <= 1'bz;
    end
    cur_s = 3'h0;
    i_host.step(2);
    wr_one(16'h0010, 8'h77, 1'b0);
    rd_one(16'h0010, 8'h77);
    $display("Test float done");
  endtask : t_float

  initial begin
    straps     = 3'h5;
    cur_s      = 3'h5;
    wp         = 1'b0;
    reset_n    = 1'b0;
    mismatches = 0;
    n_tests    = 0;
    cycles     = 0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_hold();
    t_rw();
    t_seq();
    t_strap();
    t_wp();
    t_float();
    give_verdict();
  end
endmodule : sepi_eeprom_tb

`default_nettype wire
